// >>> bench/acs_front_model.sv
// Behavioural analog front end and timer trigger source
`timescale 1ns/1ps
module acs_front_model (
  // Clock
  input wire logic core_clk_i,
  // From the converter, and fire requests from the bench
  input wire logic [2:0] conv_channel_i,
  input wire logic conv_clk_en_i,
  input wire logic [3:0] fire_i,
  // To the converter
  output logic [9:0] conv_sample_o,
  output logic [3:0] timer_trigger_o
);
  logic [9:0] junk = 10'h155;
  always_ff @(posedge core_clk_i) begin
    junk <= ~junk;
    timer_trigger_o <= fire_i;
  end
  // Value tied to the channel; a stopped converter sees a changing pattern
  assign conv_sample_o = conv_clk_en_i ? {7'h5a, conv_channel_i} : junk;
endmodule : acs_front_model

// >>> bench/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h3;
  logic xfer = 1'b0;
  logic [3:0] fire = 4'h0;
  logic ext = 1'b0;
  logic active;
  logic [31:0] rdata;
  logic wait_req;
  logic [9:0] sample;
  logic [2:0] chan;
  logic [3:0] tmr;
  logic clk_en;
  logic irq;
  logic [31:0] got;
  logic [5:0] ra [5] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h3c};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  acs_ctrl acs_ctrl_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .xfer_access_i(xfer), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .conv_sample_i(sample), .conv_channel_o(chan), .conv_active_o(active),
    .conv_clk_en_o(clk_en),
    .ext_trigger_i(ext), .timer_trigger_i(tmr), .second_timer_trigger_i(4'h0),
    .conv_end_irq_o(irq));
  acs_front_model acs_front_model_i (.core_clk_i(core_clk_i), .conv_channel_i(chan),
    .conv_clk_en_i(clk_en), .fire_i(fire), .conv_sample_o(sample), .timer_trigger_o(tmr));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] lanes);
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= lanes;
    do @(posedge core_clk_i); while (wait_req !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_flag();
    int n;
    n = 0;
    got = 32'h0;
    while (got[15] !== 1'b1 && n < 200) begin
      bus(1'b0, 6'h00, 32'h0, 4'h3);
      n++;
    end
  endtask : wait_flag
  task automatic pulse();
    @(posedge core_clk_i);
    fire <= 4'h1;
    @(posedge core_clk_i);
    fire <= 4'h0;
    repeat (8) @(posedge core_clk_i);
  endtask : pulse
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0, 4'h3);
      chk(got, rv[i]);
    end
    chk({31'h0, clk_en}, 32'h0);
    bus(1'b1, 6'h0c, 32'h0, 4'h3);
    bus(1'b1, 6'h00, 32'h4013, 4'h3);
    chk({31'h0, clk_en}, 32'h1);
    bus(1'b1, 6'h04, 32'h2000, 4'h3);
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h2000);
    chk({31'h0, active}, 32'h1);
    repeat (150) @(posedge core_clk_i);
    bus(1'b0, 6'h00, 32'h0, 4'h3);
    chk(got, 32'h4013);
    wait_flag();
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h0);
    bus(1'b0, 6'h1c, 32'h0, 4'h3);
    chk(got, {16'h0, 7'h5a, 3'h3, 6'h00});
    bus(1'b1, 6'h00, 32'h4013, 4'h1);
    bus(1'b1, 6'h00, 32'h4013, 4'h3);
    bus(1'b0, 6'h00, 32'h0, 4'h3);
    chk(got, 32'hc013);
    bus(1'b1, 6'h00, 32'h4013, 4'h3);
    bus(1'b0, 6'h00, 32'h0, 4'h3);
    chk(got, 32'h4013);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 6'h00, 32'h0013, 4'h3);
    bus(1'b1, 6'h08, 32'h3402, 4'h3);
    bus(1'b0, 6'h08, 32'h0, 4'h3);
    chk(got, 32'h3402);
    pulse();
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h0);
    bus(1'b1, 6'h00, 32'h0813, 4'h3);
    pulse();
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h2000);
    wait_flag();
    chk({31'h0, irq}, 32'h0);
    xfer <= 1'b1;
    bus(1'b0, 6'h1c, 32'h0, 4'h3);
    xfer <= 1'b0;
    bus(1'b0, 6'h00, 32'h0, 4'h3);
    chk(got, 32'h0813);
    // External pin trigger
    bus(1'b1, 6'h08, 32'h0001, 4'h3);
    ext <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h2000);
    ext <= 1'b0;
    wait_flag();
    bus(1'b1, 6'h00, 32'h0013, 4'h3);
    bus(1'b1, 6'h04, 32'h2000, 4'h3);
    repeat (20) @(posedge core_clk_i);
    bus(1'b1, 6'h04, 32'h0, 4'h3);
    repeat (300) @(posedge core_clk_i);
    bus(1'b0, 6'h00, 32'h0, 4'h3);
    chk(got, 32'h0013);
    chk({31'h0, active}, 32'h0);
    // One-pass scan over channels 0 and 1
    bus(1'b1, 6'h00, 32'h0001, 4'h3);
    bus(1'b1, 6'h04, 32'h2000, 4'h3);
    wait_flag();
    bus(1'b0, 6'h04, 32'h0, 4'h3);
    chk(got, 32'h0);
    bus(1'b0, 6'h10, 32'h0, 4'h3);
    chk(got, {16'h0, 7'h5a, 3'h0, 6'h00});
    bus(1'b0, 6'h14, 32'h0, 4'h3);
    chk(got, {16'h0, 7'h5a, 3'h1, 6'h00});
    bus(1'b1, 6'h0c, 32'h1, 4'h3);
    @(posedge core_clk_i);
    chk({31'h0, clk_en}, 32'h0);
    print_verdict();
  end
endmodule : tb_top

// >>> logic/acs_ctrl.sv
// Converter module control: registers, sequencer, triggers and end flag
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic xfer_access_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Converter front end
  input wire logic [9:0] conv_sample_i,
  output logic [2:0] conv_channel_o,
  output logic conv_active_o,
  output logic conv_clk_en_o,
  // Start triggers
  input wire logic ext_trigger_i,
  input wire logic [3:0] timer_trigger_i,
  input wire logic [3:0] second_timer_trigger_i,
  // Interrupt
  output logic conv_end_irq_o
);

  // **************************************************************************
  // Declarations
  // **************************************************************************
  acs_pkg::acs_cs_s cs;
  acs_pkg::acs_cs_s next_cs;
  acs_pkg::acs_trig_s trig;
  acs_pkg::acs_state_e st;
  acs_pkg::acs_result_s res_wr;
  logic start;
  logic mstop;
  logic run_en;
  logic pend;
  logic ack;
  logic armed;
  logic next_flag;
  logic set_flag;
  logic sw_clr;
  logic dma_clr;
  logic wr_cs;
  logic wr_start;
  logic wr_trig;
  logic wr_mstop;
  logic rd_cs;
  logic data_hit;
  logic [5:0] data_off;
  logic [2:0] data_ch;
  logic [9:0] mem_rd;
  logic [31:0] rd_mux;
  logic [7:0] valid;
  logic [2:0] div_cnt;
  logic [2:0] div_last;
  logic tick;
  logic [5:0] steps;
  logic [5:0] state_last;
  logic single;
  logic pass_end;
  logic pass_odd;
  logic flag_event;
  logic clear_start;
  logic res_wr_en;
  logic ext_q;
  logic ext_d;
  logic ext_rise;
  logic hw_go;
  logic [9:0] conv_len;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old_v;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic trig_pick(input logic [3:0] sel, input logic ext,
                                     input logic [3:0] t1, input logic [3:0] t2);
    logic [3:0] idx;
    trig_pick = 1'b0;
    idx = 4'h0;
    if (sel == `ACS_TRIG_EXT) begin
      trig_pick = ext;
    end else if (sel >= `ACS_TRIG_TIMER && sel < `ACS_TRIG_TIMER2) begin
      idx = sel - `ACS_TRIG_TIMER;
      trig_pick = t1[idx[1:0]];
    end else if (sel >= `ACS_TRIG_TIMER2 && sel < `ACS_TRIG_END) begin
      idx = sel - `ACS_TRIG_TIMER2;
      trig_pick = t2[idx[1:0]];
    end
  endfunction : trig_pick

  // **************************************************************************
  // Avalon-MM handshake and decode
  // **************************************************************************
  assign data_off = avs_address_i - `ACS_ADDR_DATA;
  assign data_ch = data_off[4:2];
  assign data_hit = (avs_address_i >= `ACS_ADDR_DATA) && (avs_address_i < `ACS_ADDR_DATA_END)
                    && (avs_address_i[1:0] == 2'b00);
  assign wr_cs = avs_write_i && ack && (avs_address_i == `ACS_ADDR_CS);
  assign wr_start = avs_write_i && ack && (avs_address_i == `ACS_ADDR_START)
                    && avs_byteenable_i[1];
  assign wr_trig = avs_write_i && ack && (avs_address_i == `ACS_ADDR_TRIG);
  assign wr_mstop = avs_write_i && ack && (avs_address_i == `ACS_ADDR_MSTOP)
                    && avs_byteenable_i[0];
  assign rd_cs = avs_read_i && ack && (avs_address_i == `ACS_ADDR_CS);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend <= 1'b0;
      ack <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else if (ack) begin
      pend <= 1'b0;
      ack <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else if (pend) begin
      ack <= 1'b1;
      avs_waitrequest_o <= 1'b0;
    end else if (avs_read_i || avs_write_i) begin
      pend <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i == `ACS_ADDR_CS) begin
      rd_mux[15:0] = cs;
    end else if (avs_address_i == `ACS_ADDR_START) begin
      rd_mux[`ACS_START_BIT] = start;
    end else if (avs_address_i == `ACS_ADDR_TRIG) begin
      rd_mux[15:0] = trig;
    end else if (avs_address_i == `ACS_ADDR_MSTOP) begin
      rd_mux[`ACS_MSTOP_BIT] = mstop;
    end else if (data_hit && valid[data_ch]) begin
      rd_mux[15:`ACS_RESULT_LSB] = mem_rd;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (pend && !ack && avs_read_i) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // **************************************************************************
  // Control registers
  // **************************************************************************
  always_comb begin
    next_cs = cs;
    if (wr_cs) begin
      next_cs = acs_pkg::acs_cs_s'(merge16(cs, avs_writedata_i, avs_byteenable_i)
                                   & `ACS_CS_WMASK);
    end
    next_cs.conv_end_flag = next_flag;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs <= acs_pkg::acs_cs_s'(`ACS_CS_RESET);
    end else begin
      cs <= next_cs;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig <= acs_pkg::acs_trig_s'(`ACS_TRIG_RESET);
    end else if (wr_trig) begin
      trig <= acs_pkg::acs_trig_s'(merge16(trig, avs_writedata_i, avs_byteenable_i));
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mstop <= `ACS_MSTOP_RESET;
      conv_clk_en_o <= ~`ACS_MSTOP_RESET;
    end else if (wr_mstop) begin
      mstop <= avs_writedata_i[`ACS_MSTOP_BIT];
      conv_clk_en_o <= ~avs_writedata_i[`ACS_MSTOP_BIT];
    end
  end

  assign run_en = !mstop;

  // **************************************************************************
  // End flag and interrupt
  // **************************************************************************
  assign single = (cs.conv_mode_select == acs_pkg::ACS_MODE_SINGLE);
  assign pass_end = (conv_channel_o == cs.input_select);
  assign flag_event = single || (pass_end && ((cs.conv_mode_select != acs_pkg::ACS_MODE_TWO_CH)
                      || cs.end_flag_control || pass_odd));
  assign set_flag = run_en && start && (st == acs_pkg::ACS_FLAG) && flag_event;
  assign sw_clr = wr_cs && avs_byteenable_i[1] && !avs_writedata_i[`ACS_CS_FLAG_BIT] && armed;
  assign dma_clr = avs_read_i && ack && data_hit && xfer_access_i;
  assign next_flag = set_flag || (cs.conv_end_flag && !(sw_clr || dma_clr));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed <= 1'b0;
    end else if (wr_cs) begin
      armed <= 1'b0;
    end else if (rd_cs && avs_readdata_o[`ACS_CS_FLAG_BIT]) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_end_irq_o <= 1'b0;
    end else begin
      conv_end_irq_o <= next_flag && next_cs.end_irq_enable;
    end
  end

  // **************************************************************************
  // Start bit and triggers
  // **************************************************************************
  acs_sync u_ext_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(ext_trigger_i),
    .q_o(ext_q)
  );

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= ext_q;
    end
  end

  assign ext_rise = ext_q && !ext_d;
  assign hw_go = run_en && cs.hw_trigger_enable
                 && (trig_pick(trig.mod0_trigger_sel, ext_rise, timer_trigger_i,
                               second_timer_trigger_i)
                     || ((cs.conv_mode_select == acs_pkg::ACS_MODE_TWO_CH)
                         && trig_pick(trig.mod0_group1_trigger_sel, ext_rise, timer_trigger_i,
                                      second_timer_trigger_i)));
  assign clear_start = run_en && start && (st == acs_pkg::ACS_CLR)
                       && (single || (pass_end && !cs.continuous_scan_bit));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start <= `ACS_START_RESET;
    end else if (wr_start) begin
      start <= avs_writedata_i[`ACS_START_BIT];
    end else if (hw_go) begin
      start <= 1'b1;
    end else if (clear_start) begin
      start <= 1'b0;
    end
  end

  // **************************************************************************
  // Conversion clock and sequencer
  // **************************************************************************
  always_comb begin
    unique case (cs.conv_clock_select)
      2'b00: div_last = `ACS_DIV_LAST_P4;
      2'b01: div_last = `ACS_DIV_LAST_P2;
      2'b10: div_last = `ACS_DIV_LAST_P1;
      2'b11: div_last = `ACS_DIV_LAST_P8;
    endcase
  end

  assign state_last = cs.state_count_select ? (`ACS_STATES_SHORT - 6'd1)
                                            : (`ACS_STATES_LONG - 6'd1);
  assign tick = run_en && (st == acs_pkg::ACS_CONV) && (div_cnt == div_last);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 3'h0;
    end else if (run_en) begin
      if ((st != acs_pkg::ACS_CONV) || (div_cnt == div_last)) begin
        div_cnt <= 3'h0;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= acs_pkg::ACS_IDLE;
      conv_channel_o <= 3'h0;
      steps <= 6'h00;
      pass_odd <= 1'b0;
    end else if (run_en) begin
      if (!start && (st != acs_pkg::ACS_IDLE)) begin
        st <= acs_pkg::ACS_IDLE;
      end else begin
        unique case (st)
          acs_pkg::ACS_IDLE: begin
            if (start) begin
              st <= acs_pkg::ACS_CONV;
              conv_channel_o <= single ? cs.input_select : 3'h0;
              steps <= 6'h00;
              pass_odd <= 1'b0;
            end
          end
          acs_pkg::ACS_CONV: begin
            if (tick) begin
              if (steps == state_last) begin
                st <= acs_pkg::ACS_STORE;
              end else begin
                steps <= steps + 6'd1;
              end
            end
          end
          acs_pkg::ACS_STORE: begin
            st <= acs_pkg::ACS_FLAG;
          end
          acs_pkg::ACS_FLAG: begin
            st <= acs_pkg::ACS_CLR;
          end
          acs_pkg::ACS_CLR: begin
            steps <= 6'h00;
            if (single || (pass_end && !cs.continuous_scan_bit)) begin
              st <= acs_pkg::ACS_IDLE;
            end else begin
              st <= acs_pkg::ACS_CONV;
              conv_channel_o <= pass_end ? 3'h0 : conv_channel_o + 3'h1;
              if (pass_end) begin
                pass_odd <= !pass_odd;
              end
            end
          end
          default: begin
            st <= acs_pkg::ACS_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_active_o <= 1'b0;
    end else begin
      conv_active_o <= run_en && (st == acs_pkg::ACS_CONV);
    end
  end

  // **************************************************************************
  // Result store
  // **************************************************************************
  assign res_wr_en = run_en && start && (st == acs_pkg::ACS_STORE);
  assign res_wr.addr = conv_channel_o;
  assign res_wr.data = conv_sample_i;

  acs_result_mem u_result_mem (
    .core_clk_i(core_clk_i),
    .wr_en_i(res_wr_en),
    .wr_i(res_wr),
    .rd_addr_i(data_ch),
    .rd_data_o(mem_rd)
  );

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid <= 8'h00;
    end else if (res_wr_en) begin
      valid[conv_channel_o] <= 1'b1;
    end
  end

  // **************************************************************************
  // Assertions
  // **************************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_len <= 10'h000;
    end else if (st != acs_pkg::ACS_CONV) begin
      conv_len <= 10'h000;
    end else if (run_en) begin
      conv_len <= conv_len + 10'h001;
    end
  end

  default clocking acs_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_store_go;
    (st == acs_pkg::ACS_STORE) && start && run_en;
  endsequence
  sequence s_flag_then_clr;
    (st == acs_pkg::ACS_FLAG) ##1 (st == acs_pkg::ACS_CLR);
  endsequence

  AST_FLAG_SET: assert property (set_flag |=> cs.conv_end_flag)
    else $error("end flag not set after completion");
  AST_FLAG_NEEDS_ARM: assert property ((wr_cs && !armed && cs.conv_end_flag) |=>
                                       cs.conv_end_flag)
    else $error("end flag cleared without prior read of one");
  AST_DMA_CLEAR: assert property ((dma_clr && !set_flag) |=> !cs.conv_end_flag)
    else $error("transfer read did not clear end flag");
  AST_IRQ_LEVEL: assert property (conv_end_irq_o == (cs.conv_end_flag && cs.end_irq_enable))
    else $error("interrupt does not match flag and enable");
  AST_TRIG_IGNORED: assert property ((!cs.hw_trigger_enable && !start && !wr_start) |=> !start)
    else $error("start set by trigger while triggers disabled");
  AST_CONV_LENGTH: assert property ((st == acs_pkg::ACS_STORE && $past(st) == acs_pkg::ACS_CONV
                                     && cs.conv_clock_select == 2'b00 && !cs.state_count_select
                                     && $stable(cs)) |-> $past(conv_len) == 10'd199)
    else $error("conversion length wrong for 50 states at divide by 4");
  AST_TICK_SPACING: assert property ((tick && cs.conv_clock_select == 2'b00) |=> !tick[*3])
    else $error("conversion clock faster than divide by 4");
  AST_START_WRITE: assert property ((wr_start && avs_writedata_i[13]) |=> start)
    else $error("start write ignored");
  AST_ABORT: assert property ((!start && st != acs_pkg::ACS_IDLE && run_en) |=>
                              st == acs_pkg::ACS_IDLE)
    else $error("converter not idle after start cleared");
  AST_SINGLE_STOP: assert property ((st == acs_pkg::ACS_CLR && run_en && start && single
                                     && !wr_start && !hw_go) |=>
                                    (!start && st == acs_pkg::ACS_IDLE))
    else $error("single mode did not clear start");
  AST_STOP_FREEZE: assert property (!run_en |=> st == $past(st))
    else $error("sequencer moved while module stopped");
  AST_DATA_LOW_ZERO: assert property ((avs_read_i && ack && data_hit) |->
                                      avs_readdata_o[5:0] == 6'h00)
    else $error("result low bits not zero");
  AST_COMPLETE_ORDER: assert property (s_store_go ##1 (run_en && start) |-> s_flag_then_clr)
    else $error("completion order wrong");
endmodule : acs_ctrl

// >>> logic/acs_result_mem.sv
// Per-channel result store with registered read data
`timescale 1ns/1ps
module acs_result_mem (
  // Clock
  input wire logic core_clk_i,
  // Write port
  input wire logic wr_en_i,
  input wire acs_pkg::acs_result_s wr_i,
  // Read port
  input wire logic [2:0] rd_addr_i,
  output logic [9:0] rd_data_o
);
  logic [9:0] mem [0:7];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_i.addr] <= wr_i.data;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : acs_result_mem

// >>> logic/acs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acs_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule : acs_sync

// >>> shared/acs_consts.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************************************************
// Register offsets (byte addresses)
// ****************************************************************************
`define ACS_ADDR_CS 6'h00
`define ACS_ADDR_START 6'h04
`define ACS_ADDR_TRIG 6'h08
`define ACS_ADDR_MSTOP 6'h0c
`define ACS_ADDR_DATA 6'h10
`define ACS_ADDR_DATA_END 6'h30

// ****************************************************************************
// Field positions
// ****************************************************************************
`define ACS_CS_FLAG_BIT 15
`define ACS_START_BIT 13
`define ACS_MSTOP_BIT 0
`define ACS_RESULT_LSB 6
`define ACS_CS_WMASK 16'h4bff

// ****************************************************************************
// Reset values
// ****************************************************************************
`define ACS_CS_RESET 16'h0000
`define ACS_START_RESET 1'b0
`define ACS_TRIG_RESET 16'h0000
`define ACS_MSTOP_RESET 1'b1

// ****************************************************************************
// Timing counts and trigger codes
// ****************************************************************************
`define ACS_STATES_LONG 6'd50
`define ACS_STATES_SHORT 6'd40
`define ACS_DIV_LAST_P4 3'd3
`define ACS_DIV_LAST_P2 3'd1
`define ACS_DIV_LAST_P1 3'd0
`define ACS_DIV_LAST_P8 3'd7
`define ACS_TRIG_EXT 4'h1
`define ACS_TRIG_TIMER 4'h2
`define ACS_TRIG_TIMER2 4'h6
`define ACS_TRIG_END 4'ha

`endif

// >>> shared/acs_pkg.sv
// Types shared by the converter control files
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_MODE_ONE_SCAN = 2'b00,
    ACS_MODE_SINGLE = 2'b01,
    ACS_MODE_CONT_SCAN = 2'b10,
    ACS_MODE_TWO_CH = 2'b11
  } acs_mode_e;

  typedef enum logic [2:0] {ACS_IDLE, ACS_CONV, ACS_STORE, ACS_FLAG, ACS_CLR} acs_state_e;

  typedef struct packed {
    logic conv_end_flag;
    logic end_irq_enable;
    logic [1:0] rsv_hi;
    logic hw_trigger_enable;
    logic rsv_mid;
    logic end_flag_control;
    logic state_count_select;
    logic [1:0] conv_clock_select;
    acs_mode_e conv_mode_select;
    logic continuous_scan_bit;
    logic [2:0] input_select;
  } acs_cs_s;

  typedef struct packed {
    logic [3:0] mod1_group1_trigger_sel;
    logic [3:0] mod0_group1_trigger_sel;
    logic [3:0] mod1_trigger_sel;
    logic [3:0] mod0_trigger_sel;
  } acs_trig_s;

  typedef struct packed {
    logic [2:0] addr;
    logic [9:0] data;
  } acs_result_s;

endpackage : acs_pkg
